// ==== core/ifa_gate_ctrl.sv ====
// Fault and alarm gate control of an isolated switch driver.
// Assumes comparator results and enables arrive as asynchronous levels.
//
// Overview of operation
// [R01] Fault comparator high forces gate drive low, fault indicator low.
// [R02] Alarm comparator high drives alarm indicator low; gate unaffected.
// [R03] Latched build: fault holds gate and indicator low until enable low with comparator clear.
// [R04] Non-latched build: fault indicator releases once comparator clears.
// [R05] Non-latched build: gate follows enable only after a recovery wait.
// [R06] Non-latched build: while fault persists, indicator and gate stay low.
// [R07] Power good, fault and alarm reported on active-low indicators.
// [R08] Controller drives enable high for gate on, low for off.
// [R09] Chip-enable low disables the device with gate drive off.
// [R10] Comparator and enable inputs synchronised; recovery count and latch mode are parameters.
module ifa_gate_ctrl
   import ifa_pkg::*;
#(
   parameter bit          LATCHED_FAULT = 1'b0,
   parameter int unsigned RECOVERY_CNT  = RECOVERY_CYCLES
)
(
   input  wire logic CLOCK,
   input  wire logic RST,
   input  wire logic ENABLE,
   input  wire logic CHIP_ENABLE,
   input  wire logic FAULT_COMPARE_INPUT,
   input  wire logic ALARM_COMPARE_INPUT,
   output logic      GATE_DRIVE_OUT,
   output logic      POWER_OK_INDICATOR_N,
   output logic      FAULT_INDICATOR_N,
   output logic      ALARM_INDICATOR_N
);
   localparam logic [REC_W-1:0] REC_LOAD = REC_W'(RECOVERY_CNT);
   // Indicators released: every active-low flag high
   localparam ifa_status_t      STAT_IDLE = '1;

   // Whole module state
   typedef struct packed {
      ifa_state_t        st;
      logic [REC_W-1:0]  rec_cnt;
      logic              gate;
      ifa_status_t       stat;
   } ifa_ctrl_state_t;

   ifa_inputs_t     raw_in;
   ifa_inputs_t     sync_in;
   ifa_ctrl_state_t s_q;
   ifa_ctrl_state_t s_d;

   assign raw_in.fault_cmp = FAULT_COMPARE_INPUT;
   assign raw_in.alarm_cmp = ALARM_COMPARE_INPUT;
   assign raw_in.enable    = ENABLE;
   assign raw_in.chip_en   = CHIP_ENABLE;

   // Every comparator and enable level crosses two flops first
   ifa_sync u_sync (                                        // R10
      .clk  (CLOCK),
      .rst  (RST),
      .din  (raw_in),
      .dout (sync_in)
   );

   // Gate may be on only when both enables are high
   function automatic logic ifa_allowed(input ifa_inputs_t i);
      return i.enable & i.chip_en;
   endfunction

   // Next-state logic; fault checked first so it beats enable
   always_comb
   begin
      s_d = s_q;
      s_d.stat.alarm_n    = ~sync_in.alarm_cmp;             // R02
      s_d.stat.power_ok_n = ~sync_in.chip_en;               // R07
      case (s_q.st)
         IFA_OFF:
         begin
            if (sync_in.fault_cmp)
               s_d.st = IFA_FAULT;                          // R01
            else if (ifa_allowed(sync_in))
               s_d.st = IFA_ON;                             // R08
         end
         IFA_ON:
         begin
            if (sync_in.fault_cmp)
               s_d.st = IFA_FAULT;                          // R01
            else if (!ifa_allowed(sync_in))
               s_d.st = IFA_OFF;                            // R09
         end
         IFA_FAULT:
         begin
            if (LATCHED_FAULT)
            begin
               // Held until enable is low and comparator clear; comparator clearing alone does not release
               if (!sync_in.enable && !sync_in.fault_cmp)
                  s_d.st = IFA_OFF;                         // R03
            end
            else if (!sync_in.fault_cmp)
            begin
               s_d.st      = IFA_RECOVER;                   // R05
               s_d.rec_cnt = REC_LOAD;
            end
         end
         IFA_RECOVER:
         begin
            if (sync_in.fault_cmp)
               s_d.st = IFA_FAULT;                          // R06
            else if (s_q.rec_cnt <= REC_ONE)
               s_d.st = IFA_OFF;                            // R05
            else
               s_d.rec_cnt = s_q.rec_cnt - REC_ONE;
         end
         default:
            s_d.st = IFA_OFF;
      endcase
      // Gate and fault flag follow the new state; fault low in FAULT only
      s_d.gate         = (s_d.st == IFA_ON);                // R01
      s_d.stat.fault_n = (s_d.st != IFA_FAULT);             // R04
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         s_q         <= '0;
         s_q.st      <= IFA_OFF;
         s_q.rec_cnt <= REC_ZERO;
         s_q.stat    <= STAT_IDLE;
      end
      else
         s_q <= s_d;
   end

   // Registered outputs
   assign GATE_DRIVE_OUT       = s_q.gate;
   assign POWER_OK_INDICATOR_N = s_q.stat.power_ok_n;       // R07
   assign FAULT_INDICATOR_N    = s_q.stat.fault_n;
   assign ALARM_INDICATOR_N    = s_q.stat.alarm_n;

   // Fault forces gate and flag low on the next edge, whatever enable does
   a_fault_gate_low: assert property ( // R01
      @(posedge CLOCK) disable iff (RST)
      sync_in.fault_cmp |=> !GATE_DRIVE_OUT && !FAULT_INDICATOR_N)
      else $error("gate not forced low on fault");

   // A low fault flag never coexists with a driven gate
   a_fault_gate_excl: assert property ( // R01
      @(posedge CLOCK) disable iff (RST)
      !FAULT_INDICATOR_N |-> !GATE_DRIVE_OUT)
      else $error("gate driven while fault flagged");

   // Alarm flag tracks the synchronised comparator one edge later
   a_alarm_follow: assert property ( // R02
      @(posedge CLOCK) disable iff (RST)
      ##1 ALARM_INDICATOR_N == !$past(sync_in.alarm_cmp))
      else $error("alarm indicator wrong");

   // Gate only drops for a fault or a lost enable, never for an alarm
   a_gate_fall_cause: assert property ( // R02
      @(posedge CLOCK) disable iff (RST)
      $fell(GATE_DRIVE_OUT)
      |-> $past(sync_in.fault_cmp) || !$past(ifa_allowed(sync_in)))
      else $error("gate dropped without cause");

   // Latched fault holds while enable stays high
   a_latch_hold: assert property ( // R03
      @(posedge CLOCK) disable iff (RST)
      (LATCHED_FAULT && s_q.st == IFA_FAULT && sync_in.enable)
      |=> !FAULT_INDICATOR_N && !GATE_DRIVE_OUT)
      else $error("latched fault released while enabled");

   // Latched flag may only clear once enable has gone low
   a_latch_release: assert property ( // R03
      @(posedge CLOCK) disable iff (RST)
      (LATCHED_FAULT && $rose(FAULT_INDICATOR_N))
      |-> !$past(sync_in.enable))
      else $error("latched fault cleared with enable high");

   // Non-latched flag lets go as soon as the comparator clears
   a_nolatch_release: assert property ( // R04
      @(posedge CLOCK) disable iff (RST)
      (!LATCHED_FAULT && s_q.st == IFA_FAULT && !sync_in.fault_cmp)
      |=> FAULT_INDICATOR_N)
      else $error("fault indicator held after clear");

   // Start of a recovery wait in the non-latched build
   sequence s_recover_start;
      !LATCHED_FAULT && s_q.st == IFA_FAULT && !sync_in.fault_cmp;
   endsequence

   a_recover_wait: assert property ( // R05
      @(posedge CLOCK) disable iff (RST)
      s_recover_start |=> !GATE_DRIVE_OUT [*2])
      else $error("gate rose before recovery");

   // Flag stays low while the comparator keeps reporting a fault
   a_fault_persist: assert property ( // R06
      @(posedge CLOCK) disable iff (RST)
      (!LATCHED_FAULT && sync_in.fault_cmp && $past(sync_in.fault_cmp))
      |=> !FAULT_INDICATOR_N)
      else $error("indicator released while fault persists");

   a_power_ok: assert property ( // R07
      @(posedge CLOCK) disable iff (RST)
      ##1 POWER_OK_INDICATOR_N == !$past(sync_in.chip_en))
      else $error("power ok indicator wrong");

   a_chip_off: assert property ( // R09
      @(posedge CLOCK) disable iff (RST)
      !sync_in.chip_en |=> !GATE_DRIVE_OUT)
      else $error("gate on while chip disabled");

   // Idle and allowed with no fault: gate turns on at the next edge
   a_enable_on: assert property ( // R08
      @(posedge CLOCK) disable iff (RST)
      (s_q.st == IFA_OFF && ifa_allowed(sync_in) && !sync_in.fault_cmp)
      |=> GATE_DRIVE_OUT)
      else $error("gate did not follow enable");

   // Gate rises only from an allowed, fault-free request
   a_gate_rise_cause: assert property ( // R09
      @(posedge CLOCK) disable iff (RST)
      $rose(GATE_DRIVE_OUT)
      |-> $past(ifa_allowed(sync_in)) && !$past(sync_in.fault_cmp))
      else $error("gate rose without enable");

   // Reset leaves gate off and every indicator released
   a_reset_idle: assert property ( // R07
      @(posedge CLOCK)
      RST |=> !GATE_DRIVE_OUT && FAULT_INDICATOR_N
              && ALARM_INDICATOR_N && POWER_OK_INDICATOR_N)
      else $error("outputs not idle after reset");
endmodule

// ==== core/ifa_pkg.sv ====
// Package for the fault and alarm gate control block.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package ifa_pkg;
   // Clock period in ns
   localparam int unsigned CLK_PERIOD_NS   = 10;
   // Recovery period after a non-latched fault clears, in ns
   localparam int unsigned RECOVERY_NS     = 1000;
   localparam int unsigned RECOVERY_CYCLES =
      (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned REC_W           = 16;
   localparam logic [REC_W-1:0] REC_ZERO   = 16'h0000;
   localparam logic [REC_W-1:0] REC_ONE    = 16'h0001;

   // Gate state machine
   typedef enum logic [1:0] {
      IFA_OFF,
      IFA_ON,
      IFA_FAULT,
      IFA_RECOVER
   } ifa_state_t;

   // Synchronised comparator and control inputs
   typedef struct packed {
      logic fault_cmp;
      logic alarm_cmp;
      logic enable;
      logic chip_en;
   } ifa_inputs_t;

   // Indicator outputs, active low
   typedef struct packed {
      logic power_ok_n;
      logic fault_n;
      logic alarm_n;
   } ifa_status_t;
endpackage

// ==== core/ifa_sync.sv ====
// Two-flop synchroniser for a bundle of input levels.
// Assumes inputs are asynchronous to CLOCK.
module ifa_sync
   import ifa_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire ifa_inputs_t din,
   output ifa_inputs_t      dout
);
   // State: both stages in one struct
   typedef struct packed {
      ifa_inputs_t meta;
      ifa_inputs_t sync;
   } ifa_sync_state_t;

   ifa_sync_state_t s_q;
   ifa_sync_state_t s_d;

   // Stage shift; only the second stage is read outside
   always_comb
   begin
      s_d      = s_q;
      s_d.meta = din;
      s_d.sync = s_q.meta;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign dout = s_q.sync;
endmodule

// ==== testbench/ifa_ctrl_model.sv ====
// Primary-side controller model: drives enable and chip-enable levels.
// Assumes the bench sets the wanted levels between clock edges.
module ifa_ctrl_model
   import ifa_pkg::*;
(
   input  wire logic CLOCK,
   input  wire logic want_en,
   input  wire logic want_ce,
   output logic      ENABLE,
   output logic      CHIP_ENABLE
);
   timeunit 1ns;
   timeprecision 100ps;
   // Levels move just after an edge, never on it; unknown only in reset
   always @(posedge CLOCK)
   begin
      ENABLE      <= #2 want_en;
      CHIP_ENABLE <= #2 want_ce;
   end
endmodule

// ==== testbench/tb.sv ====
// Bench for the fault and alarm gate control, both builds side by side.
// Assumes a short recovery count; both builds share every input.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   // Short recovery keeps the run brief
   localparam int unsigned REC = 4;
   logic        CLOCK = 1'b0;
   logic        RST   = 1'b1;
   logic        flt_c = 1'b0;
   logic        alm_c = 1'b0;
   logic        w_en  = 1'b0;
   logic        w_ce  = 1'b0;
   logic        en;
   logic        ce;
   logic [1:0]  gate;   // Bit 0 non-latched, bit 1 latched
   logic [1:0]  pok_n;
   logic [1:0]  flt_n;
   logic [1:0]  alm_n;
   logic [31:0] seed  = 32'h5e32;
   int          error_cnt = 0;
   int          n_checks  = 0;
   int          wait_n;
   // 100 MHz clock
   always #5 CLOCK = ~CLOCK;
   ifa_ctrl_model ifa_ctrl_model_inst (.CLOCK(CLOCK), .want_en(w_en),
      .want_ce(w_ce), .ENABLE(en), .CHIP_ENABLE(ce));
   // One instance per build, so latched and non-latched run in step
   for (genvar i = 0; i < 2; i++)
   begin : g
      ifa_gate_ctrl #(.LATCHED_FAULT(1'(i)), .RECOVERY_CNT(REC))
         ifa_gate_ctrl_inst (.CLOCK(CLOCK), .RST(RST), .ENABLE(en),
         .CHIP_ENABLE(ce), .FAULT_COMPARE_INPUT(flt_c),
         .ALARM_COMPARE_INPUT(alm_c), .GATE_DRIVE_OUT(gate[i]),
         .POWER_OK_INDICATOR_N(pok_n[i]), .FAULT_INDICATOR_N(flt_n[i]),
         .ALARM_INDICATOR_N(alm_n[i]));
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [1:0] both(input logic v);
      return {v, v};
   endfunction
   // Inputs and samples both sit 2 ns after the edge, clear of races
   task automatic go(input int n);
      repeat (n) @(posedge CLOCK);
      #2;
   endtask
   task automatic chk(input logic [1:0] got, input logic [1:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %b, expected %b", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Main sequence; six cycles covers model delay plus three-edge answer
   initial
   begin
      go(3);
      RST = 1'b0;
      chk(gate, 2'b00);
      chk(pok_n & flt_n & alm_n, 2'b11);
      w_en = 1'b1;
      w_ce = 1'b1;
      go(6);
      chk(gate, both(1'b1));
      chk(pok_n, both(1'b0));
      alm_c = 1'b1;
      go(5);
      chk(alm_n, both(1'b0));
      chk(gate, both(1'b1));
      flt_c = 1'b1;
      go(5);
      chk(gate | flt_n, 2'b00);
      go(20);
      chk(gate | flt_n, 2'b00);
      flt_c = 1'b0;
      alm_c = 1'b0;
      go(4);
      chk(flt_n, 2'b01);
      chk(gate, 2'b00);
      wait_n = 0;
      while (gate[0] !== 1'b1 && wait_n < 20)
      begin
         go(1);
         wait_n++;
      end
      if (gate[0] !== 1'b1)
      begin
         error_cnt++;
         $display("wrong value at %0t: recovery wait ran out", $time);
      end
      chk({1'b0, wait_n >= REC - 1}, 2'b01);
      chk(gate, 2'b01);
      chk(flt_n, 2'b01);
      w_en = 1'b0;
      go(6);
      chk(flt_n, 2'b11);
      chk(gate, 2'b00);
      w_en = 1'b1;
      go(6);
      chk(gate, 2'b11);
      w_ce = 1'b0;
      go(6);
      chk(gate, 2'b00);
      chk(pok_n, 2'b11);
      w_ce = 1'b1;
      go(6);
      chk(gate, 2'b11);
      // Fault, clear it, then fault again inside the recovery wait
      flt_c = 1'b1;
      go(5);
      chk(gate | flt_n, 2'b00);
      flt_c = 1'b0;
      go(3);
      chk(flt_n, 2'b01);
      flt_c = 1'b1;
      go(4);
      chk(gate | flt_n, 2'b00);
      // Chip-enable low must not clear a latched fault
      w_ce = 1'b0;
      go(2);
      flt_c = 1'b0;
      go(10);
      chk(flt_n, 2'b01);
      chk(gate, 2'b00);
      // Reset in mid-run clears the latched fault
      RST = 1'b1;
      go(3);
      RST = 1'b0;
      chk(gate, 2'b00);
      chk(flt_n & pok_n & alm_n, 2'b11);
      w_ce = 1'b1;
      go(6);
      chk(gate, 2'b11);
      // Random alarm and enable levels, fault kept clear
      repeat (40)
      begin
         seed = lfsr(seed);
         alm_c = seed[0];
         w_en = seed[1];
         go(6);
         chk(alm_n, both(~seed[0]));
         chk(gate, both(seed[1]));
      end
      final_report();
   end
endmodule
